// [lookup_irq_pkg.sv]
// Behaviour
// - Each mask bit gates only the status flag at the same position.
// - A pending flag reaches the interrupt pin only when its mask bit is 1.
// - Clearing a mask bit blocks the pin but the flag still records.
// - A flag reads 1 once its event occurs until read, whatever the mask.
// - The 16-bit mask is host read/write at 0x2A-0x2B and resets to zero.
// - Mask bits 6 to 2 ignore writes and read as zero.
// - Mask bits 15..8 enable new, missed new, move, missed move, secure, missed, aged, missed.
// - Mask bit 7 enables the host-set test request flag onto the pin.
// - Mask bit 1 enables the statistics half-full interrupt.
// - Mask bit 0 enables the table-memory-full interrupt.
// - Engine reports additions, moves, violations and deletions through new and aged groups.
// - Host places add and delete requests; device applies them to the table.
// - Reading a status byte clears every flag in that byte except one whose event comes in the read cycle.
// - Host reads the status register when the interrupt pin is high.
package lookup_irq_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Byte offsets on the management port
   localparam logic [7:0] STATUS_LO_OFS    = 8'h28;
   localparam logic [7:0] STATUS_HI_OFS    = 8'h29;
   localparam logic [7:0] MASK_LO_OFS      = 8'h2A;
   localparam logic [7:0] MASK_HI_OFS      = 8'h2B;
   localparam logic [7:0] ADD_DEL_CTRL_OFS = 8'h2C;
   localparam logic [7:0] NEW_REPORT_BASE  = 8'h30;
   localparam logic [7:0] NEW_PORT_HI_OFS  = 8'h37;
   localparam logic [7:0] ADD_REQ_BASE     = 8'h38;
   localparam logic [7:0] AGED_REPORT_BASE = 8'h40;
   localparam logic [7:0] AGED_PORT_OFS    = 8'h46;
   localparam logic [7:0] DEL_REQ_BASE     = 8'h48;
   localparam logic [7:0] GROUP_LEN        = 8'h08;

   ////////////////////////////////////////////////////////////////////////
   // Status and mask bit positions
   localparam int BIT_NEW         = 15;
   localparam int BIT_NEW_MISSED  = 14;
   localparam int BIT_MOVE        = 13;
   localparam int BIT_MOVE_MISSED = 12;
   localparam int BIT_SECURE      = 11;
   localparam int BIT_SECURE_MISS = 10;
   localparam int BIT_AGED        = 9;
   localparam int BIT_AGED_MISSED = 8;
   localparam int BIT_TEST        = 7;
   localparam int BIT_STAT        = 1;
   localparam int BIT_FULL        = 0;

   localparam logic [15:0] MASK_RESET    = 16'h0000;
   localparam logic [15:0] MASK_WRITABLE = 16'hFF83;
   localparam logic [7:0]  FLAGS_RESET   = 8'h00;
   localparam logic [63:0] REPORT_RESET  = 64'h0000_0000_0000_0000;

   // Control byte at the add/delete offset
   localparam int CTRL_ADD_BIT = 0;
   localparam int CTRL_DEL_BIT = 1;

   ////////////////////////////////////////////////////////////////////////
   // True when addr falls in the eight bytes starting at base
   function automatic logic inGroup(input logic [7:0] addr, input logic [7:0] base);
      inGroup = (addr >= base) && (addr < (base + GROUP_LEN));
   endfunction : inGroup

   // Byte i of a group: bytes 0..5 station address MSB first, 6 and 7 port low/high
   function automatic logic [7:0] pickByte(input logic [63:0] d, input logic [2:0] i);
      case (i)
         3'h6:    pickByte = d[7:0];
         3'h7:    pickByte = d[15:8];
         default: pickByte = d[63 - 8 * i -: 8];
      endcase
   endfunction : pickByte

   // Same layout as pickByte, for host writes
   function automatic logic [63:0] putByte(input logic [63:0] d, input logic [2:0] i,
                                           input logic [7:0] b);
      logic [63:0] r;
      r = d;
      case (i)
         3'h6:    r[7:0] = b;
         3'h7:    r[15:8] = b;
         default: r[63 - 8 * i -: 8] = b;
      endcase
      putByte = r;
   endfunction : putByte

endpackage : lookup_irq_pkg

// [sticky_flag_byte.sv]
`timescale 1ns/1ns
module sticky_flag_byte
   import lookup_irq_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [7:0] setPulse,
   input  wire logic       clearByte,
   output logic      [7:0] flags
);

   logic [7:0] flags_ff;

   ////////////////////////////////////////////////////////////////////////
   // Each flag holds until its byte is read; an event in the read cycle survives
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gFlag
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               flags_ff[g] <= 1'b0;
            end else if (setPulse[g]) begin
               flags_ff[g] <= 1'b1;
            end else if (clearByte) begin
               flags_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flags_ff;

endmodule : sticky_flag_byte

// [station_report_latch.sv]
`timescale 1ns/1ns
module station_report_latch
   import lookup_irq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        capture,
   input  wire logic [63:0] captureData,
   input  wire logic        unlock,
   output logic      [63:0] report,
   output logic             locked
);

   logic [63:0] report_ff;
   logic        locked_ff;

   ////////////////////////////////////////////////////////////////////////
   // Hold the report until the host reads the release byte, so a later
   // event cannot tear the data mid-read; such an event counts as missed
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         report_ff <= REPORT_RESET;
      end else if (capture && !locked_ff) begin
         report_ff <= captureData;
      end
   end

   // Lock follows capture; a capture in the release cycle is dropped and the lock still clears
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         locked_ff <= 1'b0;
      end else if (capture && !locked_ff) begin
         locked_ff <= 1'b1;
      end else if (unlock) begin
         locked_ff <= 1'b0;
      end
   end

   assign report = report_ff;
   assign locked = locked_ff;

endmodule : station_report_latch

// [lookup_table_interrupt_mask.sv]
`timescale 1ns/1ns
module lookup_table_interrupt_mask
   import lookup_irq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   // Management byte port
   input  wire logic [7:0]  dioAddr,
   input  wire logic [7:0]  dioWrData,
   input  wire logic        dioWrite,
   input  wire logic        dioRead,
   output logic      [7:0]  dioRdData,
   // Lookup engine events
   input  wire logic        newStationEvt,
   input  wire logic        portMoveEvt,
   input  wire logic        securedMoveEvt,
   input  wire logic [47:0] eventAddr,
   input  wire logic [3:0]  eventPortCode,
   input  wire logic [3:0]  eventOldPort,
   input  wire logic        agedEvt,
   input  wire logic [47:0] agedAddr,
   input  wire logic [3:0]  agedPortCode,
   input  wire logic        statHalfFullEvt,
   input  wire logic        tableFullEvt,
   // Host requests passed to the lookup engine
   output logic             addStationReq,
   output logic [47:0]      addStationAddr,
   output logic [15:0]      addStationPort,
   output logic             deleteStationReq,
   output logic [47:0]      deleteStationAddr,
   // Interrupt pin to the management processor
   output logic             host_interrupt_pin
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0] interrupt_enable_mask_ff;
   logic [15:0] statusFlags;
   logic [15:0] statusSet;
   logic [7:0]  dioRdData_ff;
   logic [7:0]  nxt_dioRdData;
   logic        hostIntPin_ff;
   logic [63:0] addReg_ff;
   logic [63:0] delReg_ff;
   logic        addReq_ff;
   logic        delReq_ff;
   logic [63:0] newReport;
   logic [63:0] agedReport;
   logic        newLocked;
   logic        agedLocked;
   logic        stationEvt;
   logic        wrStrobe;
   logic        rdStrobe;

   assign wrStrobe   = dioWrite;
   assign rdStrobe   = dioRead;
   assign stationEvt = newStationEvt | portMoveEvt | securedMoveEvt;

   ////////////////////////////////////////////////////////////////////////
   // Status flag sources; a locked report turns a fresh event into a missed one
   always_comb begin
      statusSet                  = 16'h0000;
      statusSet[BIT_NEW]         = newStationEvt && !newLocked;
      statusSet[BIT_NEW_MISSED]  = newStationEvt && newLocked;
      statusSet[BIT_MOVE]        = portMoveEvt && !newLocked;
      statusSet[BIT_MOVE_MISSED] = portMoveEvt && newLocked;
      statusSet[BIT_SECURE]      = securedMoveEvt && !newLocked;
      statusSet[BIT_SECURE_MISS] = securedMoveEvt && newLocked;
      statusSet[BIT_AGED]        = agedEvt && !agedLocked;
      statusSet[BIT_AGED_MISSED] = agedEvt && agedLocked;
      // Test request: host writes a 1 into the status low byte
      statusSet[BIT_TEST]        = wrStrobe && (dioAddr == STATUS_LO_OFS)
                                   && dioWrData[BIT_TEST];
      statusSet[BIT_STAT]        = statHalfFullEvt;
      statusSet[BIT_FULL]        = tableFullEvt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Status bytes, each cleared as a whole when read
   sticky_flag_byte uStatusLo (
      .clk       (clk),
      .reset     (reset),
      .setPulse  (statusSet[7:0]),
      .clearByte (rdStrobe && (dioAddr == STATUS_LO_OFS)),
      .flags     (statusFlags[7:0])
   );

   sticky_flag_byte uStatusHi (
      .clk       (clk),
      .reset     (reset),
      .setPulse  (statusSet[15:8]),
      .clearByte (rdStrobe && (dioAddr == STATUS_HI_OFS)),
      .flags     (statusFlags[15:8])
   );

   ////////////////////////////////////////////////////////////////////////
   // New / moved / secured station report, released by reading its top byte
   station_report_latch uNewReport (
      .clk         (clk),
      .reset       (reset),
      .capture     (stationEvt),
      .captureData ({eventAddr, 1'b1, 3'b000, eventPortCode, 4'h0, eventOldPort}),
      .unlock      (rdStrobe && (dioAddr == NEW_PORT_HI_OFS)),
      .report      (newReport),
      .locked      (newLocked)
   );

   // Aged station report, released by reading the aged port byte
   station_report_latch uAgedReport (
      .clk         (clk),
      .reset       (reset),
      .capture     (agedEvt),
      .captureData ({agedAddr, 8'h00, 4'h0, agedPortCode}),
      .unlock      (rdStrobe && (dioAddr == AGED_PORT_OFS)),
      .report      (agedReport),
      .locked      (agedLocked)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mask register; reserved bits never store, so they read back as zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         interrupt_enable_mask_ff <= MASK_RESET;
      end else if (wrStrobe && (dioAddr == MASK_LO_OFS)) begin
         interrupt_enable_mask_ff[7:0] <= dioWrData & MASK_WRITABLE[7:0];
      end else if (wrStrobe && (dioAddr == MASK_HI_OFS)) begin
         interrupt_enable_mask_ff[15:8] <= dioWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt pin: per-bit gating, one clock behind the flags.
   // The mask only blocks the pin; the flags above ignore it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hostIntPin_ff <= 1'b0;
      end else begin
         hostIntPin_ff <= |(statusFlags & interrupt_enable_mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host add and delete request groups, written a byte at a time
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addReg_ff <= REPORT_RESET;
      end else if (wrStrobe && inGroup(dioAddr, ADD_REQ_BASE)) begin
         addReg_ff <= putByte(addReg_ff, dioAddr[2:0], dioWrData);
      end
   end

   // Delete group has no port half; bytes 6 and 7 are not stored
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         delReg_ff <= REPORT_RESET;
      end else if (wrStrobe && inGroup(dioAddr, DEL_REQ_BASE) && !(dioAddr[2] && dioAddr[1])) begin
         delReg_ff <= putByte(delReg_ff, dioAddr[2:0], dioWrData) & 64'hFFFF_FFFF_FFFF_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control byte: writing a 1 launches the request for one clock.
   // Address is driven straight from the group register, not captured at launch, so it must be loaded first
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addReq_ff <= 1'b0;
         delReq_ff <= 1'b0;
      end else begin
         addReq_ff <= wrStrobe && (dioAddr == ADD_DEL_CTRL_OFS) && dioWrData[CTRL_ADD_BIT];
         delReq_ff <= wrStrobe && (dioAddr == ADD_DEL_CTRL_OFS) && dioWrData[CTRL_DEL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped bytes read as zero
   always_comb begin
      nxt_dioRdData = 8'h00;
      if (dioAddr == STATUS_LO_OFS) begin
         nxt_dioRdData = statusFlags[7:0];
      end else if (dioAddr == STATUS_HI_OFS) begin
         nxt_dioRdData = statusFlags[15:8];
      end else if (dioAddr == MASK_LO_OFS) begin
         nxt_dioRdData = interrupt_enable_mask_ff[7:0];
      end else if (dioAddr == MASK_HI_OFS) begin
         nxt_dioRdData = interrupt_enable_mask_ff[15:8];
      end else if (dioAddr == ADD_DEL_CTRL_OFS) begin
         nxt_dioRdData = {6'b000000, delReq_ff, addReq_ff};
      end else if (inGroup(dioAddr, NEW_REPORT_BASE)) begin
         nxt_dioRdData = pickByte(newReport, dioAddr[2:0]);
      end else if (inGroup(dioAddr, ADD_REQ_BASE)) begin
         nxt_dioRdData = pickByte(addReg_ff, dioAddr[2:0]);
      end else if (inGroup(dioAddr, AGED_REPORT_BASE) && (dioAddr[2:0] != 3'h7)) begin
         nxt_dioRdData = pickByte(agedReport, dioAddr[2:0]);
      end else if (inGroup(dioAddr, DEL_REQ_BASE)) begin
         nxt_dioRdData = pickByte(delReg_ff, dioAddr[2:0]);
      end
   end

   // Read data is registered; it holds until the next read strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dioRdData_ff <= 8'h00;
      end else if (rdStrobe) begin
         dioRdData_ff <= nxt_dioRdData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   assign dioRdData          = dioRdData_ff;
   assign host_interrupt_pin = hostIntPin_ff;
   assign addStationReq      = addReq_ff;
   assign addStationAddr     = addReg_ff[63:16];
   assign addStationPort     = addReg_ff[15:0];
   assign deleteStationReq   = delReq_ff;
   assign deleteStationAddr  = delReg_ff[63:16];

endmodule : lookup_table_interrupt_mask

// [lookup_table_interrupt_mask_chk.sv]
`timescale 1ns/1ns
module lookup_table_interrupt_mask_chk
   import lookup_irq_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [7:0] dioAddr,
   input  wire logic [7:0] dioWrData,
   input  wire logic       dioWrite,
   input  wire logic       dioRead,
   input  wire logic [7:0] dioRdData,
   input  wire logic       statHalfFullEvt,
   input  wire logic       tableFullEvt,
   input  wire logic       addStationReq,
   input  wire logic       deleteStationReq,
   input  wire logic       host_interrupt_pin
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic [15:0] maskSh_ff;

   // Shadow mask rebuilt from host writes, so no view inside the design is needed
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         maskSh_ff <= MASK_RESET;
      else if (dioWrite && dioAddr == MASK_LO_OFS)
         maskSh_ff[7:0] <= dioWrData & MASK_WRITABLE[7:0];
      else if (dioWrite && dioAddr == MASK_HI_OFS)
         maskSh_ff[15:8] <= dioWrData & MASK_WRITABLE[15:8];
   end

   ////////////////////////////////////////////////////////////
   // Host strobes; a quiet read has no low-byte event racing the clear
   sequence rdOf(logic [7:0] a);
      dioRead && dioAddr == a;
   endsequence
   sequence wrOf(logic [7:0] a);
      dioWrite && dioAddr == a;
   endsequence
   sequence rdLoQuiet;
      rdOf(STATUS_LO_OFS) ##0 (!statHalfFullEvt && !tableFullEvt);
   endsequence

   a_mask_resvd_zero: assert property (rdOf(MASK_LO_OFS) |=> dioRdData[6:2] == 5'h00)
      else $error("mask reserved bits read nonzero");
   a_mask_readback: assert property (
      wrOf(MASK_HI_OFS) ##1 rdOf(MASK_HI_OFS) |=> dioRdData == $past(dioWrData, 2))
      else $error("mask high byte readback differs");
   a_status_clear: assert property (rdLoQuiet ##1 rdLoQuiet |=> dioRdData == 8'h00)
      else $error("status byte not cleared by read");
   a_stat_records: assert property (statHalfFullEvt ##1 rdOf(STATUS_LO_OFS) |=> dioRdData[BIT_STAT])
      else $error("statistics flag not recorded");
   a_full_records: assert property (tableFullEvt ##1 rdOf(STATUS_LO_OFS) |=> dioRdData[BIT_FULL])
      else $error("table full flag not recorded");
   a_test_pin_up: assert property (
      wrOf(STATUS_LO_OFS) ##0 (dioWrData[BIT_TEST] && maskSh_ff[BIT_TEST]) |-> ##2 host_interrupt_pin)
      else $error("test request did not raise the pin");
   a_masked_quiet: assert property ((maskSh_ff == MASK_RESET) [*2] |-> !host_interrupt_pin)
      else $error("pin high with every source masked");
   a_add_pulse: assert property (
      wrOf(ADD_DEL_CTRL_OFS) ##0 dioWrData[CTRL_ADD_BIT] |=> addStationReq ##1 !addStationReq)
      else $error("add request pulse wrong");
   a_del_pulse: assert property (
      wrOf(ADD_DEL_CTRL_OFS) ##0 dioWrData[CTRL_DEL_BIT] |=> deleteStationReq ##1 !deleteStationReq)
      else $error("delete request pulse wrong");
endmodule : lookup_table_interrupt_mask_chk

bind lookup_table_interrupt_mask lookup_table_interrupt_mask_chk u_lookup_table_interrupt_mask_chk (
   .clk, .reset, .dioAddr, .dioWrData, .dioWrite, .dioRead, .dioRdData, .statHalfFullEvt,
   .tableFullEvt, .addStationReq, .deleteStationReq, .host_interrupt_pin
);

// [mgmt_host_model.sv]
`timescale 1ns/1ns
module mgmt_host_model (
   input  wire logic       clk,
   output logic      [7:0] dioAddr,
   output logic      [7:0] dioWrData,
   output logic            dioWrite,
   output logic            dioRead
);
   // Port starts idle
   initial begin
      dioAddr = 8'h00;
      dioWrData = 8'h00;
      dioWrite = 1'b0;
      dioRead = 1'b0;
   end

   // One cycle per call, set just after an edge and taken at the next one;
   // idle address and data flip so a stale byte never looks like a request
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      dioWrite <= w;
      dioRead <= r;
      dioAddr <= (w | r) ? a : ~dioAddr;
      dioWrData <= w ? d : ~dioWrData;
      @(posedge clk);
   endtask : op
endmodule : mgmt_host_model

// [lookup_table_interrupt_mask_tb_top.sv]
`timescale 1ns/1ns
module lookup_table_interrupt_mask_tb_top
   import lookup_irq_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        dioWrite, dioRead, addStationReq, deleteStationReq, host_interrupt_pin;
   logic [7:0]  dioAddr, dioWrData, dioRdData;
   logic [5:0]  evBus = 6'h00;
   logic [47:0] eventAddr = 48'h0, agedAddr = 48'h0, addStationAddr, deleteStationAddr;
   logic [3:0]  eventPortCode = 4'h0, eventOldPort = 4'h0, agedPortCode = 4'h0;
   logic [15:0] addStationPort;
   logic [63:0] v;
   logic [7:0]  rdTab [8];
   int          mismatches = 0, tests_run = 0, mMask = 0, mFlags = 0;
   int          newLk = 0, agedLk = 0, newHi = 0, agedHi = 0, k, ph, own;

   // 20 MHz clock
   always #25 clk = ~clk;

   mgmt_host_model u_mgmt_host_model (.clk, .dioAddr, .dioWrData, .dioWrite, .dioRead);
   lookup_table_interrupt_mask u_lookup_table_interrupt_mask (.clk, .reset, .dioAddr, .dioWrData, .dioWrite,
      .dioRead, .dioRdData, .newStationEvt(evBus[5]), .portMoveEvt(evBus[4]), .securedMoveEvt(evBus[3]),
      .eventAddr, .eventPortCode, .eventOldPort, .agedEvt(evBus[2]), .agedAddr, .agedPortCode,
      .statHalfFullEvt(evBus[1]), .tableFullEvt(evBus[0]), .addStationReq, .addStationAddr, .addStationPort,
      .deleteStationReq, .deleteStationAddr, .host_interrupt_pin);

   ////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: %s got %0h expected %0h", $time, m, got, exp);
      end
   endtask : chk

   // One cycle: engine events plus one host request; event data changes every cycle
   task automatic act(input logic [5:0] e, input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      evBus <= e;
      {eventAddr, agedAddr} <= {$urandom, $urandom, $urandom};
      {eventPortCode, eventOldPort, agedPortCode} <= 12'($urandom);
      u_mgmt_host_model.op(w, r, a, d);
   endtask : act

   task automatic hostWr(input logic [7:0] a, input logic [7:0] d);
      act(6'h00, 1'b1, 1'b0, a, d);
      if (a == MASK_LO_OFS) mMask = ((mMask & 16'hFF00) | d) & MASK_WRITABLE;
      if (a == MASK_HI_OFS) mMask = ((mMask & 16'h00FF) | (d << 8)) & MASK_WRITABLE;
      if (a == STATUS_LO_OFS && d[BIT_TEST]) mFlags |= 16'h0080;
   endtask : hostWr

   task automatic wrMask(input logic [15:0] m);
      hostWr(MASK_LO_OFS, m[7:0]);
      hostWr(MASK_HI_OFS, m[15:8]);
   endtask : wrMask

   // Read one byte; the model applies the read side effects at the taken edge
   task automatic rdChk(input logic [7:0] a);
      int exp;
      exp = 0;
      case (a)
         STATUS_LO_OFS: begin exp = mFlags & 16'h00FF; mFlags &= 16'hFF00; end
         STATUS_HI_OFS: begin exp = mFlags >> 8; mFlags &= 16'h00FF; end
         MASK_LO_OFS: exp = mMask & 16'h00FF;
         MASK_HI_OFS: exp = mMask >> 8;
         NEW_PORT_HI_OFS: begin exp = newHi; newLk = 0; end
         AGED_PORT_OFS: begin exp = agedHi; agedLk = 0; end
         default: exp = 0;
      endcase
      act(6'h00, 1'b0, 1'b1, a, 8'h00);
      act(6'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      chk(dioRdData, exp, "read data");
   endtask : rdChk

   // Sources 0..5 are engine pulses, 6 is the host test request
   task automatic fire(input int s);
      int b;
      if (s == 6) hostWr(STATUS_LO_OFS, 8'h80);
      else begin
         act(6'h20 >> s, 1'b0, 1'b0, 8'h00, 8'h00);
         b = (s < 3) ? 15 - 2 * s : (s == 3) ? 9 : 5 - s;
         if (s < 3) begin
            if (newLk) b--; else newHi = 8'h80 | eventPortCode;
            newLk = 1;
         end
         if (s == 3) begin
            if (agedLk) b--; else agedHi = agedPortCode;
            agedLk = 1;
         end
         mFlags |= 1 << b;
      end
   endtask : fire

   task automatic chkPin();
      act(6'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      act(6'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      chk(host_interrupt_pin, (mFlags & mMask) != 0, "interrupt pin");
   endtask : chkPin

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("[FAIL] %0t ns: run limit reached", $time);
      conclude();
   end

   ////////////////////////////////////////////////////////////
   initial begin
      rdTab = '{STATUS_LO_OFS, STATUS_HI_OFS, MASK_LO_OFS, MASK_HI_OFS, NEW_PORT_HI_OFS, AGED_PORT_OFS, 8'h20, 8'h47};
      void'($urandom(44));
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      foreach (rdTab[i]) rdChk(rdTab[i]);
      chkPin();
      $display("test reset values done");
      repeat (4) begin
         v = {$urandom, $urandom};
         wrMask(v[15:0]);
         rdChk(MASK_HI_OFS);
         rdChk(MASK_LO_OFS);
      end
      $display("test mask access done");
      // Each source alone, first masked out then masked in; sources 0 to 3 fire twice
      for (k = 0; k < 7; k++) begin
         own = (k < 4) ? 3 << (14 - 2 * k) : (k == 6) ? 16'h0080 : 1 << (5 - k);
         for (ph = 0; ph < 2; ph++) begin
            wrMask(16'(ph ? own : ~own));
            fire(k);
            if (k < 4) fire(k);
            chkPin();
            rdChk((k < 4) ? STATUS_HI_OFS : STATUS_LO_OFS);
            rdChk((k < 3) ? NEW_PORT_HI_OFS : (k == 3) ? AGED_PORT_OFS : 8'h20);
            chkPin();
         end
      end
      fire(4);
      fire(5);
      act(6'h00, 1'b0, 1'b1, STATUS_LO_OFS, 8'h00);
      mFlags &= 16'hFF00;
      rdChk(STATUS_LO_OFS);
      $display("test source masking done");
      v = {$urandom, $urandom};
      for (k = 0; k < 8; k++) hostWr(8'(ADD_REQ_BASE + k), v[63 - 8 * k -: 8]);
      for (k = 0; k < 6; k++) hostWr(8'(DEL_REQ_BASE + k), v[63 - 8 * k -: 8]);
      hostWr(ADD_DEL_CTRL_OFS, 8'h01);
      act(6'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      chk({addStationReq, addStationAddr, addStationPort}, {1'b1, v[63:16], v[7:0], v[15:8]}, "add request");
      hostWr(ADD_DEL_CTRL_OFS, 8'h02);
      chk(addStationReq, 1'b0, "add pulse length");
      act(6'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      chk({deleteStationReq, deleteStationAddr}, {1'b1, v[63:16]}, "delete request");
      $display("test add and delete done");
      // Random mix of events, mask changes and reads against the model
      repeat (80) begin
         case ($urandom % 3)
            0: fire($urandom % 7);
            1: wrMask(16'($urandom));
            default: rdChk(rdTab[$urandom % 8]);
         endcase
         chkPin();
      end
      $display("test random traffic done");
      conclude();
   end
endmodule : lookup_table_interrupt_mask_tb_top
